// File: core/timing_status_regs.sv
// Status, interrupt and time-tag register bank of the timecode board.
`timescale 1ns/10ps
`include "timing_status_params.svh"
module timing_status_regs
  import timing_status_pkg::*;
#(
  parameter int unsigned ANTENNA_HOLD = `ANTENNA_HOLD_CYCLES,
  parameter bit TIMECODE_ONLY = 1'b0
) (
  // Clock, reset and enable
  input wire logic i_core_clk,
  input wire logic i_rst,
  input wire logic i_ce,
  // Host register port
  input wire logic [7:0] i_addr,
  input wire logic i_wr,
  input wire logic i_rd,
  input wire logic [31:0] i_wdata,
  output logic [31:0] o_rdata,
  output logic o_rvalid,
  // Timing engine
  input wire time_words_t i_clock_now,
  input wire engine_state_t i_state,
  input wire engine_events_t i_events,
  input wire logic [31:0] i_resp_word,
  // Time-tag pin, command start and interrupt
  input wire logic i_tag_pin,
  output logic o_cmd_start,
  output logic o_tag_input_en,
  output logic o_irq
);
  logic tag_s1_q, tag_s2_q, tag_s3_q;
  logic tag_s1_d, tag_s2_d, tag_s3_d;
  logic [31:0] status_q, status_d;
  time_words_t clk_snap_q, clk_snap_d;
  logic [3:0] tag_cnt_q, tag_cnt_d;
  logic tag_held_q, tag_held_d;
  logic sync_prev_q, sync_prev_d;
  logic [31:0] ant_cnt_q, ant_cnt_d;
  logic [31:0] rdata_q, rdata_d;
  logic rvalid_q, rvalid_d;
  logic irq_q, irq_d;
  logic start_q, start_d;
  logic cmd_run_q, cmd_run_d;
  logic tag_addr_q, tag_addr_d;
  logic [31:0] tag_rd;
  logic tag_wr;
  logic [1:0] tag_sel;

  function automatic logic hit(input logic strobe, input logic [7:0] a, input logic [7:0] ofs);
    return strobe && (a == ofs);
  endfunction

  function automatic logic [31:0] flag_next(input logic [31:0] cur, input int b,
                                            input logic set, input logic clr);
    logic [31:0] r;
    r = cur;
    r[b] = set | (cur[b] & ~clr);
    return r;
  endfunction

  tag_time_store u_store (
    .i_core_clk(i_core_clk),
    .i_rst(i_rst),
    .i_ce(i_ce),
    .i_wr(tag_wr),
    .i_words(i_clock_now),
    .i_rd_sel(tag_sel),
    .o_rd_data(tag_rd)
  );

  always_comb begin
    logic tag_event;
    logic sync_now;
    logic acq_now;
    logic tag_read;
    logic any_irq;
    tag_event = 1'b0;
    sync_now = 1'b0;
    acq_now = 1'b0;
    tag_read = 1'b0;
    any_irq = 1'b0;
    tag_s1_d = i_tag_pin;
    tag_s2_d = tag_s1_q;
    tag_s3_d = tag_s2_q;
    status_d = status_q;
    clk_snap_d = clk_snap_q;
    tag_cnt_d = tag_cnt_q;
    tag_held_d = tag_held_q;
    ant_cnt_d = ant_cnt_q;
    cmd_run_d = cmd_run_q;
    rdata_d = 32'h0;
    rvalid_d = i_rd;
    start_d = hit(i_wr, i_addr, `OFS_CMD3);
    tag_event = tag_s2_q & ~tag_s3_q & status_q[`BIT_TAG_INPUT_EN];
    tag_read = i_rd && (i_addr >= `OFS_TAG_HIGH) && (i_addr <= `OFS_TAG_DATE);
    tag_wr = tag_event & (~tag_held_q | tag_read);
    tag_addr_d = tag_read;
    sync_now = (i_state.code_present | i_state.receiver_present) & i_state.tracking
               & ~i_state.lamp_test;
    acq_now = (i_state.code_present | i_state.receiver_present) & ~i_state.tracking
              & ~i_state.lamp_test & ~i_state.blink_yellow;
    sync_prev_d = sync_now;
    status_d[`BIT_ACQ] = acq_now;
    status_d[`BIT_SYNC] = sync_now;
    status_d = flag_next(status_d, `BIT_MATCH, i_events.match_start,
                         hit(i_wr, i_addr, `OFS_MATCH_CLEAR));
    status_d = flag_next(status_d, `BIT_PULSE, i_events.pulse,
                         hit(i_wr, i_addr, `OFS_PULSE_FLAG_CLEAR));
    status_d = flag_next(status_d, `BIT_TAG, tag_wr,
                         hit(i_rd, i_addr, `OFS_TAG_DATE));
    // Command-done only returns after a started command has left the engine.
    if (hit(i_wr, i_addr, `OFS_CMD0)) begin
      status_d[`BIT_CMD_DONE] = 1'b0;
      cmd_run_d = 1'b0;
    end else if (cmd_run_q && !i_events.cmd_busy && !start_q) begin
      status_d[`BIT_CMD_DONE] = 1'b1;
      cmd_run_d = 1'b0;
    end
    if (start_q) begin
      cmd_run_d = 1'b1;
    end
    status_d = flag_next(status_d, `BIT_SYNC_CHANGE, sync_now ^ sync_prev_q,
                         hit(i_wr, i_addr, `OFS_SYNC_CHANGE_CLEAR));
    status_d = flag_next(status_d, `BIT_OVERFLOW,
                         hit(i_wr, i_addr, `OFS_CMD3)
                         & (i_events.cmd_busy | start_q | cmd_run_q),
                         hit(i_wr, i_addr, `OFS_OVERFLOW_CLEAR));
    if (hit(i_wr, i_addr, `OFS_IRQ_ENABLE)) begin
      status_d = (status_d & ~`IRQ_EN_MASK) | (i_wdata & `IRQ_EN_MASK);
    end
    status_d[`BIT_SRC_LO +: 3] = i_state.source;
    if (ant_cnt_q != 32'h0) begin
      ant_cnt_d = ant_cnt_q - 32'h1;
    end
    status_d[`BIT_ANTENNA] = i_events.messages_ok && (ant_cnt_q == 32'h0)
                             && !TIMECODE_ONLY;
    if (tag_read) begin
      tag_cnt_d = {3'h0, tag_event};
      tag_held_d = tag_event;
    end else if (tag_event) begin
      if (tag_cnt_q != `COUNT_MAX) begin
        tag_cnt_d = tag_cnt_q + 4'h1;
      end
      tag_held_d = 1'b1;
    end
    status_d[`BIT_CNT_LO +: 4] = tag_cnt_d;
    any_irq = (status_q[`BIT_MATCH] & status_q[`BIT_EN_MATCH])
            | (status_q[`BIT_PULSE] & status_q[`BIT_EN_PULSE])
            | (status_q[`BIT_TAG] & status_q[`BIT_EN_TAG])
            | (status_q[`BIT_CMD_DONE] & status_q[`BIT_EN_CMD_DONE])
            | (status_q[`BIT_SYNC_CHANGE] & status_q[`BIT_EN_SYNC_CHANGE]);
    irq_d = any_irq;
    status_d[`BIT_IRQ_TP] = any_irq;
    status_d[31:30] = 2'h0;
    status_d[19] = 1'b0;
    status_d[15] = 1'b0;
    status_d[11] = 1'b0;
    status_d[5] = 1'b0;
    if (hit(i_rd, i_addr, `OFS_STATUS)) begin
      clk_snap_d = i_clock_now;
    end
    if (i_rd) begin
      case (i_addr)
        `OFS_STATUS: rdata_d = status_q;
        `OFS_CLK_HIGH: rdata_d = clk_snap_q.high;
        `OFS_CLK_LOW: rdata_d = clk_snap_q.low;
        `OFS_CLK_DATE: rdata_d = clk_snap_q.date;
        `OFS_TAG_STATUS: rdata_d = {28'h0, tag_cnt_q};
        `OFS_RESP3: rdata_d = i_resp_word;
        default: rdata_d = 32'h0;
      endcase
    end
  end

  // Tag words are fetched from the store one cycle before the answer.
  always_comb begin
    case (i_addr)
      `OFS_TAG_HIGH: tag_sel = 2'd0;
      `OFS_TAG_LOW: tag_sel = 2'd1;
      `OFS_TAG_DATE: tag_sel = 2'd2;
      default: tag_sel = 2'd3;
    endcase
  end

  always_ff @(posedge i_core_clk or posedge i_rst) begin
    if (i_rst) begin
      tag_s1_q <= 1'b0;
      tag_s2_q <= 1'b0;
      tag_s3_q <= 1'b0;
      status_q <= `STATUS_RESET;
      clk_snap_q <= '0;
      tag_cnt_q <= 4'h0;
      tag_held_q <= 1'b0;
      sync_prev_q <= 1'b0;
      ant_cnt_q <= ANTENNA_HOLD;
      rdata_q <= 32'h0;
      rvalid_q <= 1'b0;
      irq_q <= 1'b0;
      start_q <= 1'b0;
      cmd_run_q <= 1'b0;
      tag_addr_q <= 1'b0;
    end else if (i_ce) begin
      tag_s1_q <= tag_s1_d;
      tag_s2_q <= tag_s2_d;
      tag_s3_q <= tag_s3_d;
      status_q <= status_d;
      clk_snap_q <= clk_snap_d;
      tag_cnt_q <= tag_cnt_d;
      tag_held_q <= tag_held_d;
      sync_prev_q <= sync_prev_d;
      ant_cnt_q <= ant_cnt_d;
      rdata_q <= rdata_d;
      rvalid_q <= rvalid_d;
      irq_q <= irq_d;
      start_q <= start_d;
      cmd_run_q <= cmd_run_d;
      tag_addr_q <= tag_addr_d;
    end
  end

  // Both sources are registers; tag words come from the store's read register.
  assign o_rdata = (rvalid_q && tag_addr_q) ? tag_rd : rdata_q;
  assign o_rvalid = rvalid_q;
  assign o_irq = irq_q;
  assign o_cmd_start = start_q;
  assign o_tag_input_en = status_q[`BIT_TAG_INPUT_EN];
endmodule

// File: core/timing_status_params.svh
// Register offsets, field positions, reset values and timing counts of the status bank.
`ifndef TIMING_STATUS_PARAMS_SVH
`define TIMING_STATUS_PARAMS_SVH
`define OFS_STATUS 8'h00
`define OFS_CLK_HIGH 8'h04
`define OFS_CLK_LOW 8'h08
`define OFS_CLK_DATE 8'h0c
`define OFS_TAG_STATUS 8'h10
`define OFS_TAG_HIGH 8'h14
`define OFS_TAG_LOW 8'h18
`define OFS_TAG_DATE 8'h1c
`define OFS_CMD0 8'h20
`define OFS_CMD3 8'h2c
`define OFS_RESP0 8'h30
`define OFS_RESP3 8'h3c
`define OFS_IRQ_ENABLE 8'h00
`define OFS_MATCH_CLEAR 8'h04
`define OFS_PULSE_FLAG_CLEAR 8'h08
`define OFS_OVERFLOW_CLEAR 8'h0c
`define OFS_SIM_TAG 8'h10
`define OFS_SYNC_CHANGE_CLEAR 8'h14
`define BIT_ACQ 0
`define BIT_SYNC 1
`define BIT_MATCH 2
`define BIT_PULSE 3
`define BIT_TAG 4
`define BIT_CMD_DONE 6
`define BIT_SYNC_CHANGE 7
`define BIT_EN_MATCH 8
`define BIT_EN_PULSE 9
`define BIT_EN_TAG 10
`define BIT_EN_CMD_DONE 12
`define BIT_EN_SYNC_CHANGE 13
`define BIT_TAG_INPUT_EN 14
`define BIT_SRC_LO 16
`define BIT_ANTENNA 20
`define BIT_CNT_LO 24
`define BIT_IRQ_TP 28
`define BIT_OVERFLOW 29
`define IRQ_EN_MASK 32'h0000_7700
`define COUNT_MAX 4'hf
`define STATUS_RESET 32'h0000_0040
`define ANTENNA_HOLD_MS 3000
`define CLK_MHZ 200
`define ANTENNA_HOLD_CYCLES (`ANTENNA_HOLD_MS * 1000 * `CLK_MHZ)
`endif

// File: core/timing_status_pkg.sv
// Types shared by the status bank.
package timing_status_pkg;
  typedef enum logic [2:0] {
    SRC_SEARCH = 3'h0,
    SRC_IRIG_A = 3'h1,
    SRC_IRIG_B = 3'h2,
    SRC_NASA36 = 3'h3,
    SRC_SATELLITE = 3'h4
  } time_source_t;
  typedef struct packed {
    logic [31:0] high;
    logic [31:0] low;
    logic [31:0] date;
  } time_words_t;
  typedef struct packed {
    logic code_present;
    logic receiver_present;
    logic tracking;
    logic lamp_test;
    logic blink_yellow;
    logic [2:0] source;
  } engine_state_t;
  typedef struct packed {
    logic match_start;
    logic pulse;
    logic tag_edge;
    logic cmd_busy;
    logic messages_ok;
  } engine_events_t;
endpackage

// File: core/tag_time_store.sv
// Holds the latched time-tag words; read data comes out of a register.
`timescale 1ns/10ps
module tag_time_store
  import timing_status_pkg::*;
(
  // Clock and reset
  input wire logic i_core_clk,
  input wire logic i_rst,
  input wire logic i_ce,
  // Write side
  input wire logic i_wr,
  input wire time_words_t i_words,
  // Read side
  input wire logic [1:0] i_rd_sel,
  output logic [31:0] o_rd_data
);
  logic [31:0] mem_q [3];
  logic [31:0] rd_q;
  always_ff @(posedge i_core_clk or posedge i_rst) begin
    if (i_rst) begin
      mem_q[0] <= 32'h0;
      mem_q[1] <= 32'h0;
      mem_q[2] <= 32'h0;
      rd_q <= 32'h0;
    end else if (i_ce) begin
      if (i_wr) begin
        mem_q[0] <= i_words.high;
        mem_q[1] <= i_words.low;
        mem_q[2] <= i_words.date;
      end
      rd_q <= (i_rd_sel == 2'd3) ? 32'h0 : mem_q[i_rd_sel];
    end
  end
  assign o_rd_data = rd_q;
endmodule

// File: sim/timing_status_regs_chk.sv
// Port-level assertions of the status bank.
`timescale 1ns/10ps
`include "timing_status_params.svh"
module timing_status_regs_chk
  import timing_status_pkg::*;
#(
  parameter int unsigned ANTENNA_HOLD = 16,
  parameter bit TIMECODE_ONLY = 1'b0
) (
  // Clock and reset
  input wire logic i_core_clk,
  input wire logic i_rst,
  // Host port
  input wire logic i_ce,
  input wire logic [7:0] i_addr,
  input wire logic i_wr,
  input wire logic i_rd,
  input wire logic [31:0] i_wdata,
  input wire logic [31:0] o_rdata,
  input wire logic o_rvalid,
  // Engine side
  input wire engine_state_t i_state,
  input wire logic o_cmd_start,
  input wire logic o_tag_input_en,
  input wire logic o_irq
);
  logic [7:0] addr_q;
  logic [31:0] since_q;
  logic st;
  always_ff @(posedge i_core_clk or posedge i_rst) begin
    if (i_rst) begin
      addr_q <= '0;
      since_q <= '0;
    end else if (i_ce) begin
      addr_q <= i_addr;
      if (since_q != 32'hffff_ffff) begin
        since_q <= since_q + 32'h1;
      end
    end
  end
  assign st = o_rvalid && addr_q == `OFS_STATUS;
  default clocking @(posedge i_core_clk); endclocking
  default disable iff (i_rst);
  a_read_answer: assert property (i_ce && i_rd |=> o_rvalid)
    else $error("read without answer");
  a_rvalid_pulse: assert property (!(i_ce && i_rd) |=> !o_rvalid)
    else $error("answer without read");
  a_reserved_zero: assert property (st |-> o_rdata[31:30] == 0 && o_rdata[23:21] == 0 &&
    !o_rdata[19] && !o_rdata[15] && !o_rdata[11] && !o_rdata[5]) else $error("reserved bit set");
  a_unmapped_zero: assert property (o_rvalid && addr_q >= 8'h40 |-> o_rdata == 0)
    else $error("unmapped read not zero");
  a_lamp_masks: assert property (st && $past(i_state.lamp_test, 2) |-> o_rdata[1:0] == 0)
    else $error("lamp test shows acquire or sync");
  a_src_code: assert property (st |-> o_rdata[18:16] == $past(i_state.source, 2))
    else $error("source code wrong");
  a_irq_point: assert property (st |-> o_rdata[28] == $past(o_irq))
    else $error("interrupt testpoint wrong");
  a_tag_en_bit: assert property (st |-> o_rdata[14] == $past(o_tag_input_en))
    else $error("tag enable readback wrong");
  a_enable_write: assert property (i_ce && i_wr && i_addr == `OFS_IRQ_ENABLE |=>
    o_tag_input_en == $past(i_wdata[14])) else $error("tag enable not written");
  a_cmd_start: assert property (i_ce && i_wr && i_addr == `OFS_CMD3 |=> o_cmd_start)
    else $error("command start missing");
  a_no_start: assert property (!(i_ce && i_wr && i_addr == `OFS_CMD3) |=> !o_cmd_start)
    else $error("spurious command start");
  a_antenna_quiet: assert property (st && (TIMECODE_ONLY || since_q < ANTENNA_HOLD) |->
    !o_rdata[20]) else $error("antenna testpoint too early");
endmodule
bind timing_status_regs timing_status_regs_chk #(.ANTENNA_HOLD(ANTENNA_HOLD),
  .TIMECODE_ONLY(TIMECODE_ONLY)) u_chk (.i_core_clk, .i_rst, .i_ce, .i_addr, .i_wr, .i_rd,
  .i_wdata, .o_rdata, .o_rvalid, .i_state, .o_cmd_start, .o_tag_input_en, .o_irq);

// File: sim/host_bus_model.sv
// Host processor model that issues register reads and writes.
`timescale 1ns/10ps
`include "timing_status_params.svh"
module host_bus_model (
  // Clock and read return
  input wire logic i_core_clk,
  input wire logic [31:0] i_rdata,
  input wire logic i_rvalid,
  // Request
  output logic [7:0] o_addr = '0,
  output logic o_wr = 1'b0,
  output logic o_rd = 1'b0,
  output logic [31:0] o_wdata = '0
);
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    @(negedge i_core_clk);
    o_addr = a;
    o_wdata = d;
    o_wr = 1'b1;
    @(negedge i_core_clk);
    o_wr = 1'b0;
    o_wdata = ~d;
  endtask
  task automatic rd(input logic [7:0] a, output logic [31:0] d);
    @(negedge i_core_clk);
    o_addr = a;
    o_rd = 1'b1;
    @(negedge i_core_clk);
    o_rd = 1'b0;
    d = i_rvalid ? i_rdata : 'x;
  endtask
  task automatic cmd(input bit chk);
    logic [31:0] s;
    s = '0;
    for (int i = 0; i < 100 && chk && !s[6]; i++) rd(`OFS_STATUS, s);
    wr(`OFS_CMD0, '0);
    wr(`OFS_CMD3, 32'h10);
  endtask
  task automatic init();
    logic [31:0] s;
    wr(`OFS_MATCH_CLEAR, '0);
    wr(`OFS_PULSE_FLAG_CLEAR, '0);
    rd(`OFS_TAG_DATE, s);
  endtask
endmodule

// File: sim/timing_status_interrupt_regs_tb.sv
// Self-checking bench of the status bank against a behavioural model.
`timescale 1ns/10ps
`include "timing_status_params.svh"
module timing_status_interrupt_regs_tb;
  import timing_status_pkg::*;
  localparam int HOLD = 16;
  logic i_core_clk = 1'b0;
  logic i_rst = 1'b1;
  logic ce = 1'b1;
  logic [7:0] addr;
  logic wr, rd, rvalid, cmd_start, tag_en, irq;
  logic tag_pin = 1'b0;
  logic [31:0] wdata, rdata, r, g;
  logic [31:0] seed = 32'h6604;
  logic [31:0] m_en = '0;
  time_words_t now, snap;
  engine_state_t st = '0;
  engine_events_t ev = '0;
  bit m_match, m_pulse, m_tag, m_sc, m_ovf;
  bit m_cc = 1'b1;
  int m_cnt, cyc, bcnt, fail_count, n_tests;
  time_words_t tagq[$];
  always #2.5 i_core_clk = ~i_core_clk;
  always @(posedge i_core_clk) cyc <= i_rst ? 0 : cyc + 1;
  // Engine stays busy for a while after every command start.
  always @(negedge i_core_clk) begin
    if (cmd_start) bcnt = 20;
    else if (bcnt > 0) bcnt--;
    ev.cmd_busy = bcnt > 0;
  end
  timing_status_regs #(.ANTENNA_HOLD(HOLD)) u_dut (.i_core_clk, .i_rst, .i_ce(ce),
    .i_addr(addr), .i_wr(wr), .i_rd(rd), .i_wdata(wdata), .o_rdata(rdata), .o_rvalid(rvalid),
    .i_clock_now(now), .i_state(st), .i_events(ev), .i_resp_word(r), .i_tag_pin(tag_pin),
    .o_cmd_start(cmd_start), .o_tag_input_en(tag_en), .o_irq(irq));
  host_bus_model u_host (.i_core_clk, .i_rdata(rdata), .i_rvalid(rvalid), .o_addr(addr),
    .o_wr(wr), .o_rd(rd), .o_wdata(wdata));
  function automatic logic [31:0] rnd();
    seed ^= seed << 13;
    seed ^= seed >> 17;
    seed ^= seed << 5;
    return seed;
  endfunction
  // Sync needs a present source that is tracked, and is hidden by the lamp test.
  function automatic bit in_sync(input engine_state_t n);
    return (n.code_present | n.receiver_present) & n.tracking & ~n.lamp_test;
  endfunction
  function automatic logic [31:0] exp_st();
    logic s, a, q;
    s = in_sync(st);
    a = (st.code_present | st.receiver_present) & ~st.tracking & ~st.lamp_test & ~st.blink_yellow;
    q = |({m_sc, m_cc, m_tag, m_pulse, m_match} & {m_en[13:12], m_en[10:8]});
    return {2'b0, m_ovf, q, m_cnt[3:0], 3'b0, ev.messages_ok && cyc > HOLD, 1'b0, st.source,
      1'b0, m_en[14:12], 1'b0, m_en[10:8], m_sc, m_cc, 1'b0, m_tag, m_pulse, m_match, s, a};
  endfunction
  task automatic conclude();
    $display("%0d comparisons, %0d mismatches", n_tests, fail_count);
    if (fail_count == 0 && n_tests > 0) $display("All tests passed");
    else $display("Some tests failed");
    $finish;
  endtask
  task automatic chk(input logic [31:0] e, input logic [31:0] v);
    n_tests++;
    if (v !== e) begin
      fail_count++;
      $display("Error at %0t: got %h expected %h", $time, v, e);
    end
  endtask
  // Lets pending events land, then compares status word and interrupt line.
  task automatic sts();
    repeat (4) @(negedge i_core_clk);
    u_host.rd(`OFS_STATUS, g);
    chk(exp_st(), g);
    chk((exp_st() >> 28) & 32'h1, 32'(irq));
  endtask
  task automatic set_st(input engine_state_t n);
    @(negedge i_core_clk);
    if (in_sync(n) != in_sync(st)) m_sc = 1'b1;
    st = n;
  endtask
  task automatic hit(input int k);
    @(negedge i_core_clk);
    ev.match_start = k == 0;
    ev.pulse = k == 1;
    @(negedge i_core_clk);
    ev.match_start = 1'b0;
    ev.pulse = 1'b0;
    if (k == 0) m_match = 1'b1;
    else m_pulse = 1'b1;
  endtask
  task automatic tag();
    tag_pin = 1'b1;
    repeat (4) @(negedge i_core_clk);
    tag_pin = 1'b0;
    repeat (4) @(negedge i_core_clk);
    if (m_en[14]) begin
      m_tag = 1'b1;
      if (tagq.size() == 0) tagq.push_back(now);
      if (m_cnt < 15) m_cnt++;
    end
    now = {rnd(), rnd(), rnd()};
  endtask
  task automatic en(input logic [31:0] v);
    u_host.wr(`OFS_IRQ_ENABLE, v);
    m_en = v & `IRQ_EN_MASK;
  endtask
  initial begin
    repeat (20000) @(posedge i_core_clk);
    fail_count++;
    conclude();
  end
  initial begin
    r = rnd();
    now = {rnd(), rnd(), rnd()};
    ev.messages_ok = 1'b1;
    repeat (12) @(posedge i_core_clk);
    @(negedge i_core_clk);
    i_rst = 1'b0;
    sts();
    u_host.init();
    u_host.rd(8'h44, g);
    chk('0, g);
    u_host.rd(`OFS_RESP3, g);
    chk(r, g);
    u_host.wr(8'h44, '1);
    sts();
    $display("reset and map test done");
    for (int i = 0; i < 3; i++) begin
      en(i == 0 ? '1 : (i == 1 ? rnd() : '0));
      sts();
    end
    $display("enable test done");
    for (int i = 0; i < 8; i++) begin
      set_st({i[0], i[1], i[2], i == 5 || i == 1, i == 3, 3'(i)});
      sts();
    end
    u_host.wr(`OFS_SYNC_CHANGE_CLEAR, rnd());
    m_sc = 1'b0;
    sts();
    $display("state test done");
    en(32'h300);
    hit(0);
    sts();
    u_host.wr(`OFS_MATCH_CLEAR, rnd());
    m_match = 1'b0;
    sts();
    hit(1);
    hit(1);
    sts();
    fork
      u_host.wr(`OFS_PULSE_FLAG_CLEAR, '0);
      hit(1);
    join
    sts();
    u_host.wr(`OFS_PULSE_FLAG_CLEAR, '0);
    m_pulse = 1'b0;
    sts();
    // A heartbeat while the clock enable is low must leave no trace.
    @(negedge i_core_clk);
    ce = 1'b0;
    hit(1);
    ce = 1'b1;
    m_pulse = 1'b0;
    sts();
    $display("match and heartbeat test done");
    snap = now;
    u_host.rd(`OFS_STATUS, g);
    now = {rnd(), rnd(), rnd()};
    for (int k = 0; k < 3; k++) begin
      u_host.rd(8'(4 + 4 * k), g);
      chk(snap[95 - 32 * k -: 32], g);
    end
    $display("snapshot test done");
    en('0);
    tag();
    sts();
    en(32'h4400);
    repeat (17) tag();
    sts();
    for (int k = 0; k < 3; k++) begin
      u_host.rd(8'(8'h14 + 4 * k), g);
      chk(tagq[0][95 - 32 * k -: 32], g);
    end
    tagq.delete();
    m_tag = 1'b0;
    m_cnt = 0;
    sts();
    $display("time tag test done");
    en(32'h1000);
    u_host.cmd(1'b1);
    m_cc = 1'b0;
    sts();
    u_host.cmd(1'b0);
    m_ovf = 1'b1;
    sts();
    repeat (60) @(negedge i_core_clk);
    m_cc = 1'b1;
    sts();
    u_host.wr(`OFS_OVERFLOW_CLEAR, rnd());
    m_ovf = 1'b0;
    sts();
    $display("command test done");
    conclude();
  end
endmodule
